// File: design/sss_pkg.sv
// Purpose: Shared constants for the synchronous serial shift channel
// Assumes: 200 MHz system clock, 8-bit frames, LSB first
// Notes:   Register offsets are byte addresses on the plain register port
package sss_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SOFT_RESET_FIELD  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_TXBUF  = 8'h0C;
   localparam logic [7:0] ADDR_RXBUF  = 8'h10;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_CLK_IN     = 2;
   localparam int CTRL_EDGE_SEL   = 3;
   localparam int CTRL_DBUF       = 4;
   localparam int CTRL_IDLE_LVL   = 5;
   localparam int CTRL_EMPTY_LVL  = 6;
   localparam int CTRL_RXE        = 7;
   localparam int CTRL_TXE        = 8;
   localparam int CTRL_DMA_TX     = 9;
   localparam int CTRL_DMA_RX     = 10;
   localparam int CTRL_FIFO_EN    = 11;
   localparam int CTRL_WIDTH      = 12;
   localparam logic [11:0] CTRL_RESET = 12'h000;

   // ------------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------------
   localparam int STAT_TX_BUFFER_EMPTY_FLAG      = 0;
   localparam int STAT_RX_BUFFER_FULL_FLAG      = 1;
   localparam int STAT_TX_RUNNING_FLAG      = 2;
   localparam int STAT_OVERRUN    = 3;
   localparam int STAT_UNDERRUN   = 4;
   localparam int STAT_PARITY     = 5;
   localparam int STAT_FRAMING    = 6;
   localparam logic TX_BUFFER_EMPTY_FLAG_RESET   = 1'b1;

   // ------------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_SYNC      = 2'h0;
   localparam logic [1:0] MODE_UART9     = 2'h3;
   localparam logic [1:0] SOFT_RESET_FIELD_ARM      = 2'h2;
   localparam logic [1:0] SOFT_RESET_FIELD_FIRE     = 2'h1;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS       = 5;
   localparam int SCLK_HALF_PERIOD_NS = 80;
   localparam int SCLK_HALF_CYCLES    = (SCLK_HALF_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                        SCLK_HALF_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_SHIFT = 2'h1,
      ST_DONE  = 2'h3
   } state_type;

endpackage

// File: design/sss_channel.sv
// Purpose: Synchronous shift mode of a serial channel with soft reset and DMA gating
// Assumes: Register port on clk_sys_i; shift clock pin and serial input are asynchronous
// Notes:   In clock input mode, shift clock edges are found by oversampling on clk_sys_i
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module sss_channel #(
   parameter int HALF_CYCLES = sss_pkg::SCLK_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // Shift link pins
   input  wire logic       shift_clock_pin_i,
   output logic            shift_clock_pin_o,
   output logic            shift_clock_pin_oe_n_o,
   input  wire logic       serial_in_pin_i,
   output logic            serial_out_pin_o,
   // Asynchronous receiver strobes
   input  wire logic       uart_stop_center_i,
   input  wire logic       uart_parity_center_i,
   input  wire logic       uart_frame_bad_i,
   input  wire logic       uart_parity_bad_i,
   // Events
   output logic            transmit_irq_o,
   output logic            receive_irq_o,
   output logic            dma_tx_req_o,
   output logic            dma_rx_req_o,
   output logic            fifo_permit_o
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [11:0]            ctrl;
   logic                   soft_reset_field_armed;
   logic [7:0]             tx_buf;
   logic                   tx_buf_valid;
   logic [7:0]             tx_sh;
   logic                   tx_sh_valid;
   logic                   tx_active;
   logic [7:0]             rx_sh;
   logic                   rx_sh_full;
   logic [7:0]             rx_buf;
   logic                   rx_buffer_full_flag;
   logic                   overrun_flag;
   logic                   underrun_flag;
   logic                   parity_error_flag;
   logic                   framing_flag;
   logic [2:0]             bit_cnt;
   logic [15:0]            div_cnt;
   logic                   sclk_out;
   logic                   sclk_s1;
   logic                   sclk_s2;
   logic                   sclk_s3;
   logic                   sin_s1;
   logic                   sin_s2;
   sss_pkg::state_type     state;

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   wire logic [1:0] serial_mode_select   = ctrl[sss_pkg::CTRL_MODE_LSB +: 2];
   wire logic       clk_input_mode       = ctrl[sss_pkg::CTRL_CLK_IN];
   wire logic       edge_sel             = ctrl[sss_pkg::CTRL_EDGE_SEL];
   wire logic       double_buffer_enable = ctrl[sss_pkg::CTRL_DBUF];
   wire logic       idle_line_level      = ctrl[sss_pkg::CTRL_IDLE_LVL];
   wire logic       empty_line_level     = ctrl[sss_pkg::CTRL_EMPTY_LVL];
   wire logic       receive_enable_bit   = ctrl[sss_pkg::CTRL_RXE];
   wire logic       transmit_enable_bit  = ctrl[sss_pkg::CTRL_TXE];
   wire logic       dma_tx_enable        = ctrl[sss_pkg::CTRL_DMA_TX];
   wire logic       dma_rx_enable        = ctrl[sss_pkg::CTRL_DMA_RX];
   wire logic       fifo_enable          = ctrl[sss_pkg::CTRL_FIFO_EN];

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
      hit = (a == ref_addr);
   endfunction

   wire logic wr_ctrl   = reg_wr_i & hit(reg_addr_i, sss_pkg::ADDR_CTRL);
   wire logic wr_soft_reset_field  = reg_wr_i & hit(reg_addr_i, sss_pkg::ADDR_SOFT_RESET_FIELD);
   wire logic wr_status = reg_wr_i & hit(reg_addr_i, sss_pkg::ADDR_STATUS);
   wire logic wr_txbuf  = reg_wr_i & hit(reg_addr_i, sss_pkg::ADDR_TXBUF);
   wire logic rd_rxbuf  = reg_rd_i & hit(reg_addr_i, sss_pkg::ADDR_RXBUF);

   // Reset only on the ordered pair; any other write to the soft reset field disarms
   wire logic soft_rst  = wr_soft_reset_field & soft_reset_field_armed & (reg_wdata_i[1:0] == sss_pkg::SOFT_RESET_FIELD_FIRE);

   wire logic sync_mode = (serial_mode_select == sss_pkg::MODE_SYNC);
   wire logic out_mode  = sync_mode & ~clk_input_mode;
   wire logic in_mode   = sync_mode & clk_input_mode;

   // ------------------------------------------------------------------
   // Shift clock edges
   // ------------------------------------------------------------------
   // Clock idles at the level reached by the sampling edge
   wire logic act_lvl   = ~edge_sel;
   wire logic gen_tick  = (state == sss_pkg::ST_SHIFT) & out_mode &
                          (div_cnt == 16'(HALF_CYCLES - 1));
   wire logic in_change = in_mode & (sclk_s2 != sclk_s3);
   wire logic lead_e    = (gen_tick & (sclk_out == act_lvl)) | (in_change & (sclk_s2 != act_lvl));
   wire logic samp_e    = (gen_tick & (sclk_out != act_lvl)) | (in_change & (sclk_s2 == act_lvl));

   // ------------------------------------------------------------------
   // Transfer conditions
   // ------------------------------------------------------------------
   wire logic tx_ok     = ~transmit_enable_bit | tx_sh_valid;
   wire logic rx_ok     = (double_buffer_enable & ~transmit_enable_bit) ? ~rx_sh_full : ~rx_buffer_full_flag;
   wire logic start_out = (state == sss_pkg::ST_IDLE) & out_mode & (receive_enable_bit | transmit_enable_bit) &
                          tx_ok & rx_ok;
   wire logic start_in  = (state == sss_pkg::ST_IDLE) & in_mode & lead_e;
   wire logic first_lead = lead_e & (bit_cnt == 3'h0) &
                          ((state == sss_pkg::ST_SHIFT) | start_in);
   wire logic tx_load   = (state == sss_pkg::ST_IDLE) & tx_buf_valid & ~tx_sh_valid & ~start_in;
   wire logic frame_tx  = transmit_enable_bit & tx_sh_valid;
   wire logic done      = (state == sss_pkg::ST_DONE);
   wire logic rx_take   = done & receive_enable_bit;
   // Clock input and double buffered output receive keep the buffer separate
   wire logic rx_dbl    = in_mode | double_buffer_enable;
   wire logic done_move = rx_take & ~rx_buffer_full_flag;
   wire logic done_hold = rx_take & rx_buffer_full_flag & out_mode & rx_dbl;
   wire logic read_move = rd_rxbuf & rx_sh_full;
   wire logic ovr_set   = (rx_take & rx_buffer_full_flag & in_mode) |
                          (~sync_mode & uart_stop_center_i & rx_buffer_full_flag);
   wire logic udr_set   = in_mode & first_lead & transmit_enable_bit & ~tx_sh_valid;
   wire logic par_set   = ~sync_mode & uart_parity_center_i & uart_parity_bad_i &
                          (serial_mode_select != sss_pkg::MODE_UART9);
   wire logic frm_set   = ~sync_mode & uart_stop_center_i & uart_frame_bad_i;

   wire logic next_tx_irq = (tx_load & double_buffer_enable) |
                            (done & tx_active & ~double_buffer_enable);
   wire logic next_rx_irq = done_move | read_move;

   wire logic [15:0] status_word = {9'h000, framing_flag, parity_error_flag, underrun_flag,
                                    overrun_flag, tx_active, rx_buffer_full_flag, ~tx_buf_valid};
   wire logic [15:0] next_rdata  =
      hit(reg_addr_i, sss_pkg::ADDR_CTRL)   ? {4'h0, ctrl} :
      hit(reg_addr_i, sss_pkg::ADDR_SOFT_RESET_FIELD)  ? {15'h0000, soft_reset_field_armed} :
      hit(reg_addr_i, sss_pkg::ADDR_STATUS) ? status_word :
      hit(reg_addr_i, sss_pkg::ADDR_TXBUF)  ? {8'h00, tx_buf} :
      hit(reg_addr_i, sss_pkg::ADDR_RXBUF)  ? {8'h00, rx_buf} : 16'h0000;

   // ------------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------------
   // Clock stages reset to the idle high level, so no false edge follows reset
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
         sin_s1  <= 1'b0;
         sin_s2  <= 1'b0;
      end else begin
         sclk_s1 <= shift_clock_pin_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sin_s1  <= serial_in_pin_i;
         sin_s2  <= sin_s1;
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl        <= sss_pkg::CTRL_RESET;
         soft_reset_field_armed <= 1'b0;
      end else begin
         if (wr_soft_reset_field) begin
            soft_reset_field_armed <= (reg_wdata_i[1:0] == sss_pkg::SOFT_RESET_FIELD_ARM);
         end
         if (soft_rst) begin
            ctrl[sss_pkg::CTRL_RXE] <= 1'b0;
            ctrl[sss_pkg::CTRL_TXE] <= 1'b0;
         end else if (wr_ctrl) begin
            ctrl <= reg_wdata_i[sss_pkg::CTRL_WIDTH-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Shift sequencer and clock generator
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state    <= sss_pkg::ST_IDLE;
         bit_cnt  <= 3'h0;
         div_cnt  <= 16'h0000;
         sclk_out <= 1'b1;
      end else if (soft_rst | ~sync_mode) begin
         state    <= sss_pkg::ST_IDLE;
         bit_cnt  <= 3'h0;
         div_cnt  <= 16'h0000;
         sclk_out <= act_lvl;
      end else begin
         div_cnt <= (gen_tick | (state != sss_pkg::ST_SHIFT)) ? 16'h0000 : div_cnt + 16'h0001;
         if (gen_tick) begin
            sclk_out <= ~sclk_out;
         end else if (state == sss_pkg::ST_IDLE) begin
            sclk_out <= act_lvl;
         end
         case (state)
            sss_pkg::ST_IDLE: begin
               if (start_out | start_in) begin
                  state <= sss_pkg::ST_SHIFT;
               end
            end
            sss_pkg::ST_SHIFT: begin
               // Bit counter runs even with nothing to send
               if (samp_e) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     state <= sss_pkg::ST_DONE;
                  end
               end
            end
            sss_pkg::ST_DONE: begin
               state <= sss_pkg::ST_IDLE;
            end
            default: begin
               state <= sss_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tx_buf           <= 8'h00;
         tx_buf_valid     <= ~sss_pkg::TX_BUFFER_EMPTY_FLAG_RESET;
         tx_sh            <= 8'h00;
         tx_sh_valid      <= 1'b0;
         tx_active        <= 1'b0;
         serial_out_pin_o <= 1'b1;
      end else if (soft_rst) begin
         tx_buf_valid     <= ~sss_pkg::TX_BUFFER_EMPTY_FLAG_RESET;
         tx_sh_valid      <= 1'b0;
         tx_active        <= 1'b0;
         serial_out_pin_o <= idle_line_level;
      end else begin
         if (wr_txbuf) begin
            tx_buf <= reg_wdata_i[7:0];
         end
         tx_buf_valid <= wr_txbuf | (tx_buf_valid & ~tx_load);
         if (tx_load) begin
            tx_sh       <= tx_buf;
            tx_sh_valid <= 1'b1;
         end else if (done) begin
            tx_sh_valid <= 1'b0;
         end
         if (first_lead) begin
            tx_active <= frame_tx;
         end else if (done | ~sync_mode) begin
            tx_active <= 1'b0;
         end
         // Idle level returns a cycle after the frame, keeping hold at the delayed clock pin
         if (lead_e & (first_lead ? frame_tx : tx_active)) begin
            serial_out_pin_o <= tx_sh[bit_cnt];
         end else if (udr_set) begin
            serial_out_pin_o <= empty_line_level;
         end else if (state == sss_pkg::ST_IDLE & ~start_in) begin
            serial_out_pin_o <= idle_line_level;
         end
      end
   end

   // ------------------------------------------------------------------
   // Receive path
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rx_sh      <= 8'h00;
         rx_sh_full <= 1'b0;
         rx_buf     <= 8'h00;
         rx_buffer_full_flag      <= 1'b0;
      end else if (soft_rst) begin
         rx_sh_full <= 1'b0;
         rx_buffer_full_flag      <= 1'b0;
      end else begin
         if (samp_e & (state == sss_pkg::ST_SHIFT)) begin
            rx_sh <= {sin_s2, rx_sh[7:1]};
         end
         if (done_move) begin
            rx_buf <= rx_sh;
         end else if (read_move) begin
            rx_buf <= rx_sh;
         end
         // Held frame waits until software frees the buffer
         rx_sh_full <= done_hold | (rx_sh_full & ~read_move);
         rx_buffer_full_flag      <= done_move | read_move | (rx_buffer_full_flag & ~rd_rxbuf);
      end
   end

   // ------------------------------------------------------------------
   // Error flags, set wins over write-one clear
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         overrun_flag      <= 1'b0;
         underrun_flag     <= 1'b0;
         parity_error_flag <= 1'b0;
         framing_flag      <= 1'b0;
      end else begin
         overrun_flag      <= ovr_set |
                              (overrun_flag & ~soft_rst & ~(wr_status & reg_wdata_i[sss_pkg::STAT_OVERRUN]));
         underrun_flag     <= udr_set |
                              (underrun_flag & ~(wr_status & reg_wdata_i[sss_pkg::STAT_UNDERRUN]));
         parity_error_flag <= par_set |
                              (parity_error_flag & ~soft_rst & ~(wr_status & reg_wdata_i[sss_pkg::STAT_PARITY]));
         framing_flag      <= frm_set |
                              (framing_flag & ~(wr_status & reg_wdata_i[sss_pkg::STAT_FRAMING]));
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o            <= 16'h0000;
         shift_clock_pin_o      <= 1'b1;
         shift_clock_pin_oe_n_o <= 1'b1;
         transmit_irq_o         <= 1'b0;
         receive_irq_o          <= 1'b0;
         dma_tx_req_o           <= 1'b0;
         dma_rx_req_o           <= 1'b0;
         fifo_permit_o          <= 1'b0;
      end else begin
         reg_rdata_o            <= reg_rd_i ? next_rdata : 16'h0000;
         shift_clock_pin_o      <= sclk_out;
         shift_clock_pin_oe_n_o <= ~out_mode;
         transmit_irq_o         <= next_tx_irq;
         receive_irq_o          <= next_rx_irq;
         dma_tx_req_o           <= next_tx_irq & dma_tx_enable;
         dma_rx_req_o           <= next_rx_irq & dma_rx_enable;
         fifo_permit_o          <= fifo_enable & ~dma_tx_enable & ~dma_rx_enable;
      end
   end

endmodule

// File: test/sss_checker.sv
// Purpose: Port-level checks on sss_channel
// Assumes: Control writes are mirrored from the register port
// Notes:   Soft reset clears enable bits 7 and 8, which the mirror keeps set and no check reads
`timescale 1ns/100ps
module sss_checker (
   // Clock, reset and register port
   input wire logic        clk_sys_i, rst_i, reg_wr_i, reg_rd_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i, reg_rdata_o,
   // Link and events
   input wire logic        shift_clock_pin_o, shift_clock_pin_oe_n_o, transmit_irq_o, receive_irq_o,
   input wire logic        dma_tx_req_o, dma_rx_req_o, fifo_permit_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic [11:0] ctrl_q;
   logic        armed_q;
   wire         wr_ctrl  = reg_wr_i && reg_addr_i == sss_pkg::ADDR_CTRL;
   wire         wr_rst   = reg_wr_i && reg_addr_i == sss_pkg::ADDR_SOFT_RESET_FIELD;
   wire         fire     = wr_rst && reg_wdata_i[1:0] == sss_pkg::SOFT_RESET_FIELD_FIRE && armed_q;
   wire         fifo_ok  = ctrl_q[11] && !ctrl_q[9] && !ctrl_q[10];
   wire         out_mode = ctrl_q[2:0] == 3'h0;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q  <= 12'h000;
         armed_q <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata_i[11:0];
         if (wr_rst) armed_q <= reg_wdata_i[1:0] == sss_pkg::SOFT_RESET_FIELD_ARM;
      end
   end
   property p_dma_tx; dma_tx_req_o == (transmit_irq_o && $past(ctrl_q[9])); endproperty
   a_dma_tx: assert property (p_dma_tx) else $error("tx dma request out of step");
   property p_dma_rx; dma_rx_req_o == (receive_irq_o && $past(ctrl_q[10])); endproperty
   a_dma_rx: assert property (p_dma_rx) else $error("rx dma request out of step");
   property p_fifo; fifo_permit_o == $past(fifo_ok); endproperty
   a_fifo: assert property (p_fifo) else $error("fifo permit wrong");
   property p_oe; !shift_clock_pin_oe_n_o |-> $past(out_mode); endproperty
   a_oe: assert property (p_oe) else $error("clock driven outside clock output mode");
   property p_tx_rest; transmit_irq_o && !shift_clock_pin_oe_n_o |=> $stable(shift_clock_pin_o) [*2]; endproperty
   a_tx_rest: assert property (p_tx_rest) else $error("clock runs after last bit");
   property p_rx_pulse; receive_irq_o |=> !receive_irq_o; endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq longer than a cycle");
   property p_soft_reset_field; fire |-> ##3 ($stable(shift_clock_pin_o) && !transmit_irq_o && !receive_irq_o) [*4]; endproperty
   a_soft_reset_field: assert property (p_soft_reset_field) else $error("activity after soft reset");
   property p_rd_zero; !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle");
   c_dma_tx: cover property (dma_tx_req_o);
   c_dma_rx: cover property (dma_rx_req_o);
   c_fire: cover property (fire);
endmodule
bind sss_channel sss_checker i_sss_checker (.clk_sys_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
   .reg_rdata_o, .shift_clock_pin_o, .shift_clock_pin_oe_n_o, .transmit_irq_o, .receive_irq_o, .dma_tx_req_o,
   .dma_rx_req_o, .fifo_permit_o);

// File: test/sss_partner.sv
// Purpose: External shift partner
// Assumes: Clock idles high, data moves on falling edges
// Notes:   Clock runs only for the eight bits of a frame
`timescale 1ns/100ps
module sss_partner (
   // Link side
   input  wire logic       sck_i, sout_i, go_i,
   input  wire logic [7:0] tx_i,
   output logic            pclk_o, sin_o,
   output logic [7:0]      rx_o
);
   logic [7:0] sh;
   initial begin
      pclk_o = 1'b1;
      sin_o = 1'b0;
      rx_o = 8'h00;
      sh = 8'h00;
   end
   // Odd offset keeps the link out of phase with the system clock
   always @(posedge go_i) begin
      #33 sh = tx_i;
      repeat (8) begin
         #80 pclk_o = 1'b0;
         #80 pclk_o = 1'b1;
      end
   end
   // Spent bits come back inverted, so a stale line never matches
   always @(negedge sck_i) begin
      sin_o <= sh[0];
      sh <= {~sh[0], sh[7:1]};
   end
   always @(posedge sck_i) rx_o <= {sout_i, rx_o[7:1]};
endmodule

// File: test/sss_channel_bench.sv
// Purpose: Self-checking bench for sss_channel
// Assumes: Default half period of the generated clock
// Notes:   Asynchronous receiver strobes held low
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h seen %h", n, e, g); end end
module sss_channel_bench;
   logic        clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, go = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00, ptx = 8'h00, prx;
   logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
   logic        sclk_o, oe_n, sout, sin, pclk, tx_irq, rx_irq, dma_tx, dma_rx, fifo_ok;
   int          checked = 0, n_fail = 0;
   wire         sck = oe_n ? pclk : sclk_o;
   always #2.5 clk_sys_i = ~clk_sys_i;
   sss_channel i_sss_channel (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .shift_clock_pin_i(sck), .shift_clock_pin_o(sclk_o), .shift_clock_pin_oe_n_o(oe_n), .serial_in_pin_i(sin),
      .serial_out_pin_o(sout), .uart_stop_center_i(1'b0), .uart_parity_center_i(1'b0), .uart_frame_bad_i(1'b0),
      .uart_parity_bad_i(1'b0), .transmit_irq_o(tx_irq), .receive_irq_o(rx_irq), .dma_tx_req_o(dma_tx),
      .dma_rx_req_o(dma_rx), .fifo_permit_o(fifo_ok));
   sss_partner i_sss_partner (.sck_i(sck), .sout_i(sout), .go_i(go), .tx_i(ptx), .pclk_o(pclk), .sin_o(sin),
      .rx_o(prx));
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_sys_i);
      `CHK(n, e, reg_rdata_o)
   endtask
   task automatic irq_wait(input bit rx);
      repeat (600) begin
         @(negedge clk_sys_i);
         if ((rx ? rx_irq : tx_irq) === 1'b1) break;
      end
   endtask
   task automatic send_frame(input logic [7:0] d);
      ptx <= d;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
   endtask
   task automatic close_out;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic t_regs;
      rdc(sss_pkg::ADDR_CTRL, 16'h0000, "ctrl reset");
      rdc(sss_pkg::ADDR_STATUS, 16'h0001, "status reset");
      rdc(8'h20, 16'h0000, "unmapped");
      wr(sss_pkg::ADDR_CTRL, 16'h0800);
      repeat (2) @(negedge clk_sys_i);
      `CHK("fifo permit", 1'b1, fifo_ok)
      wr(sss_pkg::ADDR_CTRL, 16'h0A00);
      repeat (2) @(negedge clk_sys_i);
      `CHK("fifo blocked", 1'b0, fifo_ok)
   endtask
   task automatic t_out;
      wr(sss_pkg::ADDR_CTRL, 16'h0300);
      wr(sss_pkg::ADDR_TXBUF, 16'h00A5);
      irq_wait(1'b0);
      `CHK("tx irq", 1'b1, tx_irq)
      `CHK("dma tx", 1'b1, dma_tx)
      `CHK("tx byte", 8'hA5, prx)
      rdc(sss_pkg::ADDR_STATUS, 16'h0001, "no run errors");
      send_frame(8'h96);
      wr(sss_pkg::ADDR_CTRL, 16'h0480);
      irq_wait(1'b1);
      `CHK("rx irq", 1'b1, rx_irq)
      `CHK("dma rx", 1'b1, dma_rx)
      rdc(sss_pkg::ADDR_RXBUF, 16'h0096, "rx byte");
   endtask
   task automatic t_in;
      wr(sss_pkg::ADDR_SOFT_RESET_FIELD, 16'h0002);
      wr(sss_pkg::ADDR_SOFT_RESET_FIELD, 16'h0001);
      wr(sss_pkg::ADDR_CTRL, 16'h05C4);
      send_frame(8'h3C);
      irq_wait(1'b1);
      `CHK("in rx irq", 1'b1, rx_irq)
      `CHK("in dma rx", 1'b1, dma_rx)
      `CHK("empty level", 8'hFF, prx)
      send_frame(8'h81);
      repeat (300) @(negedge clk_sys_i);
      rdc(sss_pkg::ADDR_STATUS, 16'h001B, "over and underrun");
      rdc(sss_pkg::ADDR_RXBUF, 16'h003C, "held frame");
   endtask
   task automatic t_soft_reset_field;
      wr(sss_pkg::ADDR_SOFT_RESET_FIELD, 16'h0001);
      wr(sss_pkg::ADDR_SOFT_RESET_FIELD, 16'h0002);
      rdc(sss_pkg::ADDR_CTRL, 16'h05C4, "wrong order");
      wr(sss_pkg::ADDR_SOFT_RESET_FIELD, 16'h0001);
      rdc(sss_pkg::ADDR_CTRL, 16'h0444, "ctrl after reset");
      rdc(sss_pkg::ADDR_STATUS, 16'h0011, "status after reset");
   endtask
   task automatic t_dbl;
      wr(sss_pkg::ADDR_CTRL, 16'h0110);
      wr(sss_pkg::ADDR_TXBUF, 16'h005A);
      irq_wait(1'b0);
      `CHK("load irq", 1'b1, tx_irq)
      `CHK("dma tx off", 1'b0, dma_tx)
      rdc(sss_pkg::ADDR_STATUS, 16'h0011, "empty after move");
      irq_wait(1'b0);
      `CHK("no irq when dry", 1'b0, tx_irq)
      `CHK("dbl byte", 8'h5A, prx)
      `CHK("clock parked", 1'b1, sclk_o)
   endtask
   initial begin
      #100000;
      n_fail++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_regs();
      t_out();
      t_in();
      t_soft_reset_field();
      t_dbl();
      close_out();
   end
endmodule
